// file: hdl/sar_frame_ctrl.v
// Converter state machine and 32-bit serial frame engine
`timescale 1ns/1ps
`include "sar_frame_defs.vh"
module sar_frame_ctrl #(
   parameter CONV_CYCLES = `CONV_CYCLES,
   parameter RST_POR_CYCLES = `RST_POR_CYCLES,
   parameter RST_APP_CYCLES = `RST_APP_CYCLES
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Device pins
   input wire reset_n_pin,
   input wire conversion_start_chip_select,
   input wire sclk,
   input wire sdi,
   output reg primary_serial_output,
   output reg primary_serial_output_oe,
   output reg ready_indicator,
   // Configuration
   input wire reset_pin_function_select,
   input wire launch_on_rising,
   // Result word into the output path
   input wire [`FRAME_BITS-1:0] result_data,
   input wire result_valid,
   output wire result_ready,
   // Decoded command word, sample pulse and reset flag out
   output reg [`FRAME_BITS-1:0] command_word,
   output reg command_valid,
   output reg sample_pulse,
   output reg app_reset_active
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   reg [1:0] rstn_s_q;
   reg [1:0] cs_s_q;
   reg [1:0] sck_s_q;
   reg [1:0] sdi_s_q;
   reg cs_prev_q;
   reg sck_prev_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rstn_s_q <= 2'h0;
         cs_s_q <= 2'h3;
         sck_s_q <= 2'h0;
         sdi_s_q <= 2'h0;
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         rstn_s_q <= {rstn_s_q[0], reset_n_pin};
         cs_s_q <= {cs_s_q[0], conversion_start_chip_select};
         sck_s_q <= {sck_s_q[0], sclk};
         sdi_s_q <= {sdi_s_q[0], sdi};
         cs_prev_q <= cs_s_q[1];
         sck_prev_q <= sck_s_q[1];
      end
   end
   wire rstn_live = rstn_s_q[1];
   wire cs_fall = cs_prev_q && !cs_s_q[1];
   wire cs_rise = !cs_prev_q && cs_s_q[1];
   wire sck_rise = !sck_prev_q && sck_s_q[1];
   wire sck_fall = sck_prev_q && !sck_s_q[1];
   // Capture on the edge opposite to launch; mode 0 captures rising
   wire capture_edge = launch_on_rising ? sck_fall : sck_rise;
   wire launch_edge = launch_on_rising ? sck_rise : sck_fall;

   // ==========================================================
   // Output word buffer
   // ==========================================================
   wire [`FRAME_BITS-1:0] fifo_data;
   wire fifo_valid;
   reg fifo_pop;
   word_fifo #(
      .WIDTH(`FRAME_BITS),
      .DEPTH(`FIFO_DEPTH),
      .AW(3)
   ) u_out_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(result_valid),
      .in_ready(result_ready),
      .in_data(result_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ==========================================================
   // State machine
   // ==========================================================
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [15:0] timer_q;
   reg [15:0] timer_d;
   reg in_frame_q;
   reg app_mode_q;
   wire in_reset = !rstn_live;
   always @* begin
      state_d = state_q;
      timer_d = timer_q;
      case (state_q)
         `ST_RESET: begin
            // Leave reset only with select and clock low
            if (rstn_live && !cs_s_q[1] && !sck_s_q[1]) begin
               state_d = `ST_RECOVER;
               timer_d = app_mode_q ? RST_APP_CYCLES[15:0] : RST_POR_CYCLES[15:0];
            end
         end
         `ST_RECOVER: begin
            if (timer_q <= 16'h0001) begin
               state_d = `ST_ACQ;
            end else begin
               timer_d = timer_q - 16'h0001;
            end
         end
         `ST_ACQ: begin
            if (cs_rise) begin
               state_d = `ST_CONV;
               timer_d = CONV_CYCLES[15:0];
            end
         end
         `ST_CONV: begin
            // Select edges are not looked at here
            if (timer_q <= 16'h0001) begin
               state_d = `ST_ACQ;
            end else begin
               timer_d = timer_q - 16'h0001;
            end
         end
         default: begin
            state_d = `ST_RESET;
         end
      endcase
      if (in_reset) begin
         state_d = `ST_RESET;
      end
   end

   // ==========================================================
   // Frame engine
   // ==========================================================
   reg [`FRAME_BITS-1:0] in_sr_q;
   reg [`FRAME_BITS-1:0] out_sr_q;
   reg [5:0] cnt_q;
   always @* begin
      fifo_pop = (state_q == `ST_ACQ) && cs_fall && fifo_valid && !in_reset;
   end
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= `ST_RESET;
         timer_q <= 16'h0000;
         in_frame_q <= 1'b0;
         app_mode_q <= 1'b0;
         in_sr_q <= `NOP_WORD;
         out_sr_q <= `NOP_WORD;
         cnt_q <= 6'h00;
         primary_serial_output <= 1'b0;
         primary_serial_output_oe <= 1'b0;
         ready_indicator <= 1'b0;
         command_word <= `NOP_WORD;
         command_valid <= 1'b0;
         sample_pulse <= 1'b0;
         app_reset_active <= 1'b0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         command_valid <= 1'b0;
         sample_pulse <= 1'b0;
         if (in_reset) begin
            // Reset kind latched on the first cycle the pin reads low
            if (state_q != `ST_RESET) begin
               app_mode_q <= reset_pin_function_select;
            end
            in_frame_q <= 1'b0;
            in_sr_q <= `NOP_WORD;
            out_sr_q <= `NOP_WORD;
            cnt_q <= 6'h00;
            primary_serial_output_oe <= 1'b0;
            ready_indicator <= 1'b0;
            app_reset_active <= app_mode_q;
         end else begin
            app_reset_active <= 1'b0;
            if (state_q == `ST_RECOVER && state_d == `ST_ACQ) begin
               ready_indicator <= 1'b1;
            end
            if (state_q == `ST_CONV && state_d == `ST_ACQ) begin
               ready_indicator <= 1'b1;
            end
            // Frames only open in the acquisition state
            if (state_q == `ST_ACQ && cs_fall) begin
               in_frame_q <= 1'b1;
               cnt_q <= 6'h00;
               in_sr_q <= `NOP_WORD;
               out_sr_q <= fifo_valid ? fifo_data : `NOP_WORD;
               primary_serial_output <= fifo_valid ? fifo_data[`FRAME_BITS-1] : 1'b0;
               primary_serial_output_oe <= 1'b1;
               ready_indicator <= 1'b0;
            end else if (in_frame_q && cs_rise) begin
               in_frame_q <= 1'b0;
               primary_serial_output_oe <= 1'b0;
               ready_indicator <= 1'b0;
               sample_pulse <= 1'b1;
               // Short frame decodes as no-op, long keeps last 32 bits
               command_word <= (cnt_q == `CNT_SATURATE) ? in_sr_q : `NOP_WORD;
               command_valid <= 1'b1;
            end else if (!in_frame_q && state_q == `ST_ACQ && cs_rise) begin
               ready_indicator <= 1'b0;
               sample_pulse <= 1'b1;
            end else if (in_frame_q) begin
               if (capture_edge) begin
                  in_sr_q <= {in_sr_q[`FRAME_BITS-2:0], sdi_s_q[1]};
                  // Captured bits trail the word out, so a chain passes data through
                  out_sr_q <= {out_sr_q[`FRAME_BITS-2:0], sdi_s_q[1]};
                  if (cnt_q != `CNT_SATURATE) begin
                     cnt_q <= cnt_q + 6'h01;
                  end
               end
               if (launch_edge) begin
                  // No shift on launch: a launch-first mode still sends bit 31 first
                  primary_serial_output <= out_sr_q[`FRAME_BITS-1];
               end
            end
         end
      end
   end
endmodule

// file: hdl/sar_frame_defs.vh
// Constants for the converter state machine and serial frame logic
`ifndef SAR_FRAME_DEFS_VH
`define SAR_FRAME_DEFS_VH
`define FRAME_BITS 32
`define NOP_WORD 32'h00000000
`define CNT_SATURATE 6'h20
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + 9) / 10)
`define RST_POR_TIME_NS 20000
`define RST_POR_CYCLES ((`RST_POR_TIME_NS + 9) / 10)
`define RST_APP_TIME_NS 1000
`define RST_APP_CYCLES ((`RST_APP_TIME_NS + 9) / 10)
`define ST_RESET 2'h0
`define ST_ACQ 2'h1
`define ST_CONV 2'h2
`define ST_RECOVER 2'h3
`define FIFO_DEPTH 8
`endif

// file: hdl/word_fifo.v
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         // Pointers wrap at 2**AW, which matches DEPTH only when DEPTH is 2**AW
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// file: tb/sar_frame_ctrl_monitor.sv
// Port checker for the converter frame controller
`timescale 1ns/1ps
module sar_frame_ctrl_monitor #(
   parameter CONV_CYCLES = 100
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Pins and flags
   input wire reset_n_pin,
   input wire conversion_start_chip_select,
   input wire primary_serial_output_oe,
   input wire ready_indicator,
   input wire command_valid,
   input wire sample_pulse,
   input wire app_reset_active
);
   reg [15:0] conv_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Cycles since the accepted start; cleared once ready is back
   always @(posedge mclk or posedge rst) begin
      if (rst) conv_q <= 16'h0000;
      else if (sample_pulse) conv_q <= 16'h0001;
      else if (ready_indicator) conv_q <= 16'h0000;
      else if (conv_q != 16'h0000) conv_q <= conv_q + 16'h0001;
   end
   // ====
   // Assertions
   a_frame_open: assert property ($fell(conversion_start_chip_select) && ready_indicator
      |-> ##[2:5] primary_serial_output_oe && !ready_indicator) else $error("frame start not seen");
   a_frame_close: assert property ($rose(conversion_start_chip_select) && primary_serial_output_oe
      |-> ##[2:5] !primary_serial_output_oe) else $error("output not released");
   a_cmd_sample: assert property (command_valid |-> sample_pulse) else $error("command without sample");
   a_cmd_single: assert property (command_valid |=> !command_valid) else $error("command pulse too long");
   a_conv_quiet: assert property (sample_pulse |=> !sample_pulse [*8]) else $error("start taken in convert");
   a_conv_ready: assert property (sample_pulse |-> !ready_indicator ##[1:300] ready_indicator)
      else $error("ready not back after convert");
   a_conv_length: assert property ($rose(ready_indicator) && conv_q != 16'h0000
      |-> conv_q >= CONV_CYCLES - 2) else $error("conversion too short");
   a_app_reset: assert property (app_reset_active |-> !ready_indicator && !primary_serial_output_oe)
      else $error("outputs active in reset");
   a_reset_recover: assert property ($rose(reset_n_pin) |-> !ready_indicator [*8])
      else $error("ready before recovery");
   a_reset_idle: assert property (!reset_n_pin [*4] |-> !primary_serial_output_oe && !sample_pulse)
      else $error("activity in reset");
   c_cmd: cover property (command_valid);
   c_app: cover property (app_reset_active);
   c_rdy: cover property ($rose(ready_indicator));
endmodule

// file: tb/spi_host_model.sv
// Host serial master model driving select, clock and data
`timescale 1ns/1ps
module spi_host_model (
   // Clock
   input wire mclk,
   // Serial lines
   input wire miso,
   output logic sel,
   output logic sck,
   output logic mosi
);
   initial begin
      sel = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Clock stands low outside frames; 8 cycles per half period
   task automatic frame(input logic [63:0] tx, input int n, input logic mode, output logic [63:0] rx);
      rx = 64'h0;
      sel = 1'b0;
      step(8);
      for (int i = n - 1; i >= 0; i--) begin
         if (mode) sck = 1'b1;
         mosi = tx[i];
         step(8);
         sck = ~mode;
         rx = {rx[62:0], miso};
         step(8);
         sck = 1'b0;
      end
      // Data not selected: show the inverse, never the last bit
      mosi = ~mosi;
      sel = 1'b1;
   endtask
endmodule

// file: tb/tb_sar_frame_ctrl.sv
// Self-checking bench for the converter frame controller
`timescale 1ns/1ps
module tb_sar_frame_ctrl;
   logic mclk;
   logic rst;
   logic reset_n_pin;
   logic reset_pin_function_select;
   logic launch_on_rising;
   logic [31:0] result_data;
   logic result_valid;
   wire sel, sck, mosi, pso, oe, rdy, res_rdy, cmd_v, smp, app;
   wire sdo_line;
   wire [31:0] cmd;
   logic [31:0] last_cmd = 32'h0;
   logic [63:0] rx;
   int ncmd = 0;
   int nsmp = 0;
   int err_total = 0;
   int total_checks = 0;
   always #5 mclk = ~mclk;
   sar_frame_ctrl #(.CONV_CYCLES(10), .RST_POR_CYCLES(20), .RST_APP_CYCLES(10)) dut (.mclk(mclk), .rst(rst),
      .reset_n_pin(reset_n_pin), .conversion_start_chip_select(sel), .sclk(sck), .sdi(mosi),
      .primary_serial_output(pso), .primary_serial_output_oe(oe), .ready_indicator(rdy),
      .reset_pin_function_select(reset_pin_function_select), .launch_on_rising(launch_on_rising),
      .result_data(result_data), .result_valid(result_valid), .result_ready(res_rdy),
      .command_word(cmd), .command_valid(cmd_v), .sample_pulse(smp), .app_reset_active(app));
   // Released line shows the inverse, so a late enable is caught
   assign sdo_line = oe ? pso : ~pso;
   spi_host_model host (.mclk(mclk), .miso(sdo_line), .sel(sel), .sck(sck), .mosi(mosi));
   always @(posedge mclk) begin
      if (cmd_v === 1'b1) begin
         ncmd <= ncmd + 1;
         last_cmd <= cmd;
      end
      if (smp === 1'b1) begin
         nsmp <= nsmp + 1;
      end
   end
   // ====
   // Shared tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_rdy(output int n);
      n = 0;
      while (rdy !== 1'b1 && n < 5000) begin
         host.step(1);
         n++;
      end
      chk(64'(n < 5000), 64'h1, "ready timeout");
   endtask
   task automatic fill(input logic [31:0] w [$]);
      foreach (w[i]) begin
         result_data = w[i];
         result_valid = 1'b1;
         do @(posedge mclk); while (res_rdy !== 1'b1);
         #1;
      end
      result_valid = 1'b0;
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ====
   // Scenarios
   task automatic t_reset_exit();
      int n;
      host.step(3);
      reset_n_pin = 1'b1;
      wait_rdy(n);
      chk(64'(n >= 20), 64'h1, "power-on recovery");
      host.sel = 1'b1;
      host.step(6);
      chk(64'(rdy), 64'h0, "ready in convert");
      wait_rdy(n);
   endtask
   task automatic t_fifo_frames();
      logic [31:0] w [$];
      logic [63:0] tx, ex;
      int n, m, k;
      for (int i = 0; i < 8; i++) w.push_back(32'h9E37_79B9 * (i + 1));
      fill(w);
      chk(64'(res_rdy), 64'h0, "buffer full");
      for (int i = 0; i < 9; i++) begin
         n = (i == 1) ? 16 : (i == 2) ? 40 : 32;
         tx = {32'hC3A5_0F96 ^ i, 32'h5A3C_E187 + i};
         ex = (i == 8) ? 64'h0 : (n == 40) ? {24'h0, w[i], tx[39:32]} : 64'(w[i] >> (32 - n));
         k = ncmd;
         host.frame(tx, n, 1'b0, rx);
         wait_rdy(m);
         chk(rx, ex, "shifted out word");
         chk({32'(ncmd - k), last_cmd}, {32'h1, (n >= 32) ? tx[31:0] : 32'h0}, "command");
      end
   endtask
   task automatic t_conv_ignore();
      int k, n, s;
      k = ncmd;
      s = nsmp;
      host.frame(64'h1234_5678, 32, 1'b0, rx);
      host.step(5);
      host.sel = 1'b0;
      host.step(3);
      host.sel = 1'b1;
      wait_rdy(n);
      host.step(10);
      chk({32'(ncmd - k), 31'h0, oe}, 64'h1_0000_0000, "select in convert");
      chk(64'(nsmp - s), 64'h1, "samples in convert");
   endtask
   task automatic t_app_reset();
      int n;
      reset_pin_function_select = 1'b1;
      reset_n_pin = 1'b0;
      host.step(6);
      host.sel = 1'b0;
      host.step(4);
      chk({app, rdy, oe}, 3'b100, "application reset pins");
      reset_n_pin = 1'b1;
      wait_rdy(n);
      chk(64'(n >= 10), 64'h1, "application recovery");
      host.sel = 1'b1;
      host.step(6);
      wait_rdy(n);
      reset_pin_function_select = 1'b0;
   endtask
   task automatic t_mode_rising();
      int k, n;
      launch_on_rising = 1'b1;
      fill('{32'hA5C3_0F1E});
      k = ncmd;
      host.frame(64'hFACE_0B5E, 32, 1'b1, rx);
      wait_rdy(n);
      chk({32'(ncmd - k), last_cmd}, 64'h1_FACE_0B5E, "rising launch command");
      chk(rx, 64'hA5C3_0F1E, "rising launch word");
      launch_on_rising = 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      reset_n_pin = 1'b0;
      reset_pin_function_select = 1'b0;
      launch_on_rising = 1'b0;
      result_data = 32'h0000_0000;
      result_valid = 1'b0;
      host.step(20);
      rst = 1'b0;
      t_reset_exit();
      t_fifo_frames();
      t_conv_ignore();
      t_app_reset();
      t_mode_rising();
      report_and_stop();
   end
   // Whole run is near 6k cycles; allow over six times that
   initial begin
      #400000;
      err_total++;
      report_and_stop();
   end
endmodule
bind sar_frame_ctrl sar_frame_ctrl_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon (.mclk(mclk), .rst(rst),
   .reset_n_pin(reset_n_pin), .conversion_start_chip_select(conversion_start_chip_select),
   .primary_serial_output_oe(primary_serial_output_oe), .ready_indicator(ready_indicator),
   .command_valid(command_valid), .sample_pulse(sample_pulse), .app_reset_active(app_reset_active));
